/* File: scc_defs.svh */
// Purpose : constants for the second comparator control block
// Assumes : 32-bit apb data, one register per aligned word
// Notes   : register index times four gives the byte address
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH

// ---------------------------------------------------------------
// register indices and byte addresses
// ---------------------------------------------------------------
`define SCC_IDX_CTRL    10'h11a
`define SCC_IDX_AUX     10'h11b
`define SCC_IDX_STATUS  10'h11c
`define SCC_IDX_MASK    10'h11d
`define SCC_ADDR_CTRL   {`SCC_IDX_CTRL, 2'b00}
`define SCC_ADDR_AUX    {`SCC_IDX_AUX, 2'b00}
`define SCC_ADDR_STATUS {`SCC_IDX_STATUS, 2'b00}
`define SCC_ADDR_MASK   {`SCC_IDX_MASK, 2'b00}

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SCC_CTRL_ON     7
`define SCC_CTRL_RES    6
`define SCC_CTRL_PINEN  5
`define SCC_CTRL_INV    4
`define SCC_CTRL_FAST   3
`define SCC_CTRL_REF    2
`define SCC_CTRL_SEL_HI 1
`define SCC_CTRL_SEL_LO 0
`define SCC_AUX_MIR1    7
`define SCC_AUX_MIR2    6
`define SCC_AUX_TSYNC   0
`define SCC_IRQ_CHANGE  0

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SCC_RST_CTRL    7'h00
`define SCC_RST_AUX     1'h0
`define SCC_RST_IRQ     1'h0

`endif

/* File: scc_pkg.sv */
// Purpose : types for the second comparator control block
// Assumes : nothing
// Notes   : constants live in scc_defs.svh
`default_nettype none

package scc_pkg;

    // -----------------------------------------------------------
    // writable fields of the main control register
    // -----------------------------------------------------------
    typedef struct packed {
        logic       cmp2_power_on;
        logic       cmp2_pin_drive_en;
        logic       cmp2_invert;
        logic       cmp2_fast_mode;
        logic       cmp2_ref_select;
        logic [1:0] cmp2_input_select;
    } scc_ctrl_t;

    // -----------------------------------------------------------
    // pin qualifiers from the rest of the chip
    // -----------------------------------------------------------
    typedef struct packed {
        logic portb_direction;
        logic switcher_on;
        logic switcher_dual_output;
        logic slope_comp_on;
    } scc_pin_qual_t;

    // -----------------------------------------------------------
    // result source used for status and pin
    // -----------------------------------------------------------
    typedef enum logic [0:0] {
        SCC_SRC_ASYNC = 1'b0,
        SCC_SRC_TIMER = 1'b1
    } scc_src_t;

endpackage

`default_nettype wire

/* File: scc_sync.sv */
// Purpose : two flip-flop synchroniser for asynchronous levels
// Assumes : synchronous active-low reset
// Notes   : first stage is read only by the second
`default_nettype none

module scc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);

    logic [W-1:0] meta_reg;

    // -----------------------------------------------------------
    // per-bit two stage chain
    // -----------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
                meta_reg[i] <= 1'b0;
                q_o[i]      <= 1'b0;
            end else begin
                meta_reg[i] <= d_i[i];
                q_o[i]      <= meta_reg[i];
            end
        end
    end

endmodule

`default_nettype wire

/* File: scc_ctrl.sv */
// Purpose : control and status of the second analog comparator
// Assumes : 20 MHz clk_i, apb slave, comparator output asynchronous
// Notes   : analog blocks sit outside; this drives their selects
`default_nettype none
`include "scc_defs.svh"

module scc_ctrl #(
    parameter int AW = 12
) (
    input  wire logic          clk_i,
    input  wire logic          rstn_i,
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [AW-1:0] paddr_i,
    input  wire logic [31:0]   pwdata_i,
    output var  logic          pready_o,
    output var  logic [31:0]   prdata_o,
    output var  logic          pslverr_o,
    input  wire logic          cmp2_raw_i,
    input  wire logic          mirror_result_first_i,
    input  wire logic          timer1_clock_input_i,
    input  wire scc_pkg::scc_pin_qual_t pin_qual_i,
    output var  logic          cmp2_power_on_o,
    output var  logic          cmp2_fast_mode_o,
    output var  logic          cmp2_ref_select_o,
    output var  logic [1:0]    cmp2_input_select_o,
    output var  logic          cmp2_pin_out_o,
    output var  logic          cmp2_pin_oe_n_o,
    output var  logic          irq_o
);

    // -----------------------------------------------------------
    // storage
    // -----------------------------------------------------------
    scc_pkg::scc_ctrl_t ctrl_reg;
    scc_pkg::scc_src_t  src_sel;
    logic               timer_sync_reg;
    logic               result_reg;
    logic               result_next;
    logic               held_reg;
    logic               t1_prev_reg;
    logic               mirror1_reg;
    logic               status_reg;
    logic               mask_reg;
    logic [31:0]        prdata_reg;
    logic [31:0]        rd_next;
    logic               synced;
    logic               t1_fall;
    logic               eff_raw;
    logic               pin_drive;
    logic               change_evt;

    // -----------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------
    logic setup_ph;
    logic wr_acc;
    logic hit_ctrl;
    logic hit_aux;
    logic hit_status;
    logic hit_mask;
    logic hit_any;

    assign hit_ctrl   = (paddr_i == AW'(`SCC_ADDR_CTRL));
    assign hit_aux    = (paddr_i == AW'(`SCC_ADDR_AUX));
    assign hit_status = (paddr_i == AW'(`SCC_ADDR_STATUS));
    assign hit_mask   = (paddr_i == AW'(`SCC_ADDR_MASK));
    assign hit_any    = hit_ctrl | hit_aux | hit_status | hit_mask;
    assign setup_ph   = psel_i & ~penable_i;
    assign wr_acc     = psel_i & penable_i & pwrite_i & hit_any;

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit_any;
    assign prdata_o  = prdata_reg;

    // -----------------------------------------------------------
    // synchroniser on the raw comparison
    // -----------------------------------------------------------
    scc_sync #(
        .W (1)
    ) u_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    (cmp2_raw_i),
        .q_o    (synced)
    );

    // -----------------------------------------------------------
    // control register writes
    // -----------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl_reg <= scc_pkg::scc_ctrl_t'(`SCC_RST_CTRL);
        end else if (wr_acc && hit_ctrl) begin
            ctrl_reg.cmp2_power_on     <= pwdata_i[`SCC_CTRL_ON];
            ctrl_reg.cmp2_pin_drive_en <= pwdata_i[`SCC_CTRL_PINEN];
            ctrl_reg.cmp2_invert       <= pwdata_i[`SCC_CTRL_INV];
            ctrl_reg.cmp2_fast_mode    <= pwdata_i[`SCC_CTRL_FAST];
            ctrl_reg.cmp2_ref_select   <= pwdata_i[`SCC_CTRL_REF];
            ctrl_reg.cmp2_input_select <=
                pwdata_i[`SCC_CTRL_SEL_HI:`SCC_CTRL_SEL_LO];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            timer_sync_reg <= `SCC_RST_AUX;
        end else if (wr_acc && hit_aux) begin
            timer_sync_reg <= pwdata_i[`SCC_AUX_TSYNC];
        end
    end

    // -----------------------------------------------------------
    // analog controls
    // -----------------------------------------------------------
    assign cmp2_power_on_o     = ctrl_reg.cmp2_power_on;
    assign cmp2_fast_mode_o    = ctrl_reg.cmp2_fast_mode;
    assign cmp2_ref_select_o   = ctrl_reg.cmp2_ref_select;
    assign cmp2_input_select_o = ctrl_reg.cmp2_input_select;

    // -----------------------------------------------------------
    // timer1 falling edge capture
    // -----------------------------------------------------------
    assign t1_fall = t1_prev_reg & ~timer1_clock_input_i;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            t1_prev_reg <= 1'b0;
        end else begin
            t1_prev_reg <= timer1_clock_input_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            held_reg <= 1'b0;
        end else if (t1_fall) begin
            held_reg <= synced;
        end
    end

    assign src_sel = timer_sync_reg ? scc_pkg::SCC_SRC_TIMER
                                    : scc_pkg::SCC_SRC_ASYNC;

    always_comb begin
        case (src_sel)
            scc_pkg::SCC_SRC_ASYNC: eff_raw = synced;
            scc_pkg::SCC_SRC_TIMER: eff_raw = held_reg;
            default:                eff_raw = synced;
        endcase
    end

    // -----------------------------------------------------------
    // result latch and pin
    // -----------------------------------------------------------
    assign result_next = ctrl_reg.cmp2_power_on
                       & (eff_raw ^ ctrl_reg.cmp2_invert);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            result_reg  <= 1'b0;
            mirror1_reg <= 1'b0;
        end else begin
            result_reg  <= result_next;
            mirror1_reg <= mirror_result_first_i;
        end
    end

    assign pin_drive = ctrl_reg.cmp2_power_on
                     & ctrl_reg.cmp2_pin_drive_en
                     & ~pin_qual_i.portb_direction
                     & (~pin_qual_i.switcher_on
                        | (~pin_qual_i.switcher_dual_output
                           & ~pin_qual_i.slope_comp_on));

    assign cmp2_pin_out_o  = result_next;
    assign cmp2_pin_oe_n_o = ~pin_drive;

    // -----------------------------------------------------------
    // interrupt status and mask
    // -----------------------------------------------------------
    assign change_evt = ctrl_reg.cmp2_power_on
                      & (result_next != result_reg);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            status_reg <= `SCC_RST_IRQ;
        end else if (change_evt) begin
            status_reg <= 1'b1;
        end else if (wr_acc && hit_status && pwdata_i[`SCC_IRQ_CHANGE]) begin
            status_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            mask_reg <= `SCC_RST_IRQ;
        end else if (wr_acc && hit_mask) begin
            mask_reg <= pwdata_i[`SCC_IRQ_CHANGE];
        end
    end

    assign irq_o = status_reg & mask_reg;

    // -----------------------------------------------------------
    // read data, captured in the setup cycle
    // -----------------------------------------------------------
    always_comb begin
        rd_next = 32'h0;
        if (hit_ctrl) begin
            rd_next[`SCC_CTRL_ON]    = ctrl_reg.cmp2_power_on;
            rd_next[`SCC_CTRL_RES]   = result_reg;
            rd_next[`SCC_CTRL_PINEN] = ctrl_reg.cmp2_pin_drive_en;
            rd_next[`SCC_CTRL_INV]   = ctrl_reg.cmp2_invert;
            rd_next[`SCC_CTRL_FAST]  = ctrl_reg.cmp2_fast_mode;
            rd_next[`SCC_CTRL_REF]   = ctrl_reg.cmp2_ref_select;
            rd_next[`SCC_CTRL_SEL_HI:`SCC_CTRL_SEL_LO] =
                ctrl_reg.cmp2_input_select;
        end else if (hit_aux) begin
            rd_next[`SCC_AUX_MIR1]  = mirror1_reg;
            rd_next[`SCC_AUX_MIR2]  = result_reg;
            rd_next[`SCC_AUX_TSYNC] = timer_sync_reg;
        end else if (hit_status) begin
            rd_next[`SCC_IRQ_CHANGE] = status_reg;
        end else if (hit_mask) begin
            rd_next[`SCC_IRQ_CHANGE] = mask_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            prdata_reg <= 32'h0;
        end else if (setup_ph && !pwrite_i) begin
            prdata_reg <= rd_next;
        end
    end

    // -----------------------------------------------------------
    // checks
    // -----------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_raw_rise;
        !cmp2_raw_i ##1 cmp2_raw_i [*3];
    endsequence

    sequence s_aux_read;
        psel_i && !penable_i && !pwrite_i && hit_aux;
    endsequence

    sequence s_ctrl_write_on;
        wr_acc && hit_ctrl && pwdata_i[`SCC_CTRL_ON];
    endsequence

    sequence s_timer_fall;
        timer1_clock_input_i ##1 !timer1_clock_input_i;
    endsequence

    a_off_no_drive: assert property (
        !ctrl_reg.cmp2_power_on |-> cmp2_pin_oe_n_o && !cmp2_pin_out_o
    ) else $error("pin driven while comparator off");

    a_pin_gate_ok: assert property (
        !cmp2_pin_oe_n_o |-> ctrl_reg.cmp2_pin_drive_en
            && !pin_qual_i.portb_direction
            && (!pin_qual_i.switcher_on || (!pin_qual_i.switcher_dual_output
                && !pin_qual_i.slope_comp_on))
    ) else $error("pin driven without all conditions");

    a_oe_internal_only: assert property (
        s_ctrl_write_on ##1 !ctrl_reg.cmp2_pin_drive_en |-> cmp2_pin_oe_n_o
    ) else $error("pin driven with output enable clear");

    a_status_latch_lag: assert property (
        $past(ctrl_reg.cmp2_power_on) && !$past(timer_sync_reg)
            |-> result_reg == ($past(synced) ^ $past(ctrl_reg.cmp2_invert))
    ) else $error("status bit not latched from comparator");

    a_sync_two_stage: assert property (
        s_raw_rise |-> synced
    ) else $error("synchroniser latency wrong");

    a_timer_hold_value: assert property (
        timer_sync_reg && !t1_fall |=> $stable(held_reg)
    ) else $error("synced result moved without timer fall");

    a_aux_gap_zero: assert property (
        s_aux_read |=> prdata_o[5:1] == 5'h00
    ) else $error("aux unused bits not zero");

    a_mirror_both_res: assert property (
        s_aux_read |=> prdata_o[7:6] == {$past(mirror1_reg), $past(result_reg)}
    ) else $error("mirror bits mismatch");

    a_irq_on_change: assert property (
        $past(ctrl_reg.cmp2_power_on) && $changed(result_reg) |-> status_reg
    ) else $error("change interrupt not raised");

    a_reset_clears_regs: assert property (@(posedge clk_i) disable iff (1'b0)
        !rstn_i |=> ctrl_reg == scc_pkg::scc_ctrl_t'(`SCC_RST_CTRL)
            && !timer_sync_reg
    ) else $error("control registers not cleared by reset");

    a_result_tracks_pin: assert property (
        1'b1 |=> result_reg == $past(cmp2_pin_out_o)
    ) else $error("status bit does not latch the pin value");

    a_fall_takes_sample: assert property (
        s_timer_fall |=> held_reg == $past(synced)
    ) else $error("timer fall did not capture the result");

    a_change_sets_flag: assert property (
        change_evt |=> status_reg
    ) else $error("change event lost against a clear");

    a_clear_drops_flag: assert property (
        wr_acc && hit_status && pwdata_i[`SCC_IRQ_CHANGE] && !change_evt |=> !status_reg
    ) else $error("change flag not cleared by a one");

    a_power_write_lands: assert property (
        wr_acc && hit_ctrl |=> cmp2_power_on_o == $past(pwdata_i[`SCC_CTRL_ON])
    ) else $error("enable bit write not applied");

    a_speed_write_lands: assert property (
        wr_acc && hit_ctrl |=> cmp2_fast_mode_o == $past(pwdata_i[`SCC_CTRL_FAST])
    ) else $error("speed bit write not applied");

endmodule

`default_nettype wire

/* File: scc_analog_model.sv */
// Purpose : far side model: analog inputs, references, timer1 clock
// Assumes : levels are 8-bit codes, higher code means higher voltage
// Notes   : timer clock stands at 0 unless the bench asks it to run
`default_nettype none

module scc_analog_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] ain_i,
    input  wire logic [7:0]  dac_level_i,
    input  wire logic [7:0]  vref_level_i,
    input  wire logic        power_on_i,
    input  wire logic        ref_select_i,
    input  wire logic [1:0]  input_select_i,
    input  wire logic        timer_run_i,
    output var  logic        raw_o,
    output var  logic        timer1_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // comparison
    // ---------------------------------------------------------------
    logic [7:0] plus_lvl;
    logic [7:0] minus_lvl;
    logic [1:0] tcnt = 2'h0;
    logic       tclk_reg = 1'b0;

    assign plus_lvl  = ref_select_i ? dac_level_i : vref_level_i;
    assign minus_lvl = ain_i[input_select_i*8 +: 8];
    assign raw_o     = power_on_i & (plus_lvl > minus_lvl);

    // ---------------------------------------------------------------
    // timer1 clock, four system cycles per half period
    // ---------------------------------------------------------------
    assign timer1_clk_o = tclk_reg;
    always @(posedge clk_i) begin
        tcnt <= tcnt + 2'h1;
        if (!timer_run_i) begin
            tclk_reg <= 1'b0;
        end else if (tcnt == 2'h3) begin
            tclk_reg <= ~tclk_reg;
        end
    end
endmodule

`default_nettype wire

/* File: second_comparator_control_tb_top.sv */
// Purpose : self-checking bench for scc_ctrl
// Assumes : apb master with zero-wait slave, analog model as far side
// Notes   : reference 25, dac 35, inputs 10 20 30 40
`default_nettype none
`include "scc_defs.svh"

module second_comparator_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic                   clk_i     = 1'b0;
    logic                   rstn_i    = 1'b0;
    logic                   psel      = 1'b0;
    logic                   penable   = 1'b0;
    logic                   pwrite    = 1'b0;
    logic [11:0]            paddr     = 12'h000;
    logic [31:0]            pwdata    = 32'h0;
    logic                   mir_first = 1'b0;
    logic                   tmr_run   = 1'b0;
    scc_pkg::scc_pin_qual_t qual      = '0;
    logic                   pready, pslverr, raw, t1clk, serr;
    logic                   on_o, fast_o, ref_o, pin_o, oe_n_o, irq;
    logic [1:0]             sel_o;
    logic [31:0]            prdata, rdata;
    int                     bad_count, check_count, cycles;

    always #25 clk_i = ~clk_i;

    scc_ctrl #(.AW(12)) i_scc_ctrl (
        .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
        .prdata_o(prdata), .pslverr_o(pslverr), .cmp2_raw_i(raw),
        .mirror_result_first_i(mir_first), .timer1_clock_input_i(t1clk),
        .pin_qual_i(qual), .cmp2_power_on_o(on_o), .cmp2_fast_mode_o(fast_o),
        .cmp2_ref_select_o(ref_o), .cmp2_input_select_o(sel_o),
        .cmp2_pin_out_o(pin_o), .cmp2_pin_oe_n_o(oe_n_o), .irq_o(irq)
    );

    scc_analog_model i_scc_analog_model (
        .clk_i(clk_i), .ain_i({8'd40, 8'd30, 8'd20, 8'd10}), .dac_level_i(8'd35),
        .vref_level_i(8'd25), .power_on_i(on_o), .ref_select_i(ref_o),
        .input_select_i(sel_o), .timer_run_i(tmr_run), .raw_o(raw),
        .timer1_clk_o(t1clk)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rdata   = prdata;
        serr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rdata, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    function automatic logic above(input logic [1:0] s, input logic r);
        logic [7:0] minus;
        minus = 8'd10 + 8'd10 * s;
        return (r ? 8'd35 : 8'd25) > minus;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        logic       e;
        logic [7:0] c;
        idle(12);
        rstn_i <= 1'b1;
        rd("ctrl_reset", `SCC_ADDR_CTRL, 32'h0);
        rd("aux_reset", `SCC_ADDR_AUX, 32'h0);
        chk("on_reset", on_o, 1'b0);
        for (int k = 0; k < 16; k++) begin
            c = {3'b101, k[3], k[0], k[2], k[1:0]};
            e = above(k[1:0], k[2]) ^ k[3];
            wr(`SCC_ADDR_CTRL, {24'h0, c});
            idle(5);
            rd("ctrl_result", `SCC_ADDR_CTRL, {24'h0, c[7], e, c[5:0]});
            chk("pin_out", pin_o, e);
            chk("input_sel", sel_o, k[1:0]);
            chk("ref_sel", ref_o, k[2]);
            chk("fast", fast_o, k[0]);
            chk("power_on", on_o, 1'b1);
        end
        for (int i = 0; i < 32; i++) begin
            qual <= scc_pkg::scc_pin_qual_t'(i[3:0]);
            wr(`SCC_ADDR_CTRL, {24'h0, 2'b10, i[4], 5'h0});
            idle(3);
            chk("pin_oe_n", oe_n_o, !(i[4] & !i[3] & (!i[2] | (!i[1] & !i[0]))));
        end
        qual <= '0;
        wr(`SCC_ADDR_CTRL, 32'h20);
        idle(5);
        chk("off_oe_n", oe_n_o, 1'b1);
        chk("off_pin", pin_o, 1'b0);
        rd("off_ctrl", `SCC_ADDR_CTRL, 32'h20);
        mir_first <= 1'b1;
        wr(`SCC_ADDR_CTRL, 32'h80);
        wr(`SCC_ADDR_AUX, 32'hfe);
        idle(5);
        rd("aux_mirror", `SCC_ADDR_AUX, 32'hc0);
        mir_first <= 1'b0;
        idle(3);
        rd("aux_mirror_lo", `SCC_ADDR_AUX, 32'h40);
        for (int pe = 0; pe < 2; pe++) begin
            wr(`SCC_ADDR_CTRL, {24'h0, 2'b10, pe[0], 5'h0});
            idle(5);
            wr(`SCC_ADDR_STATUS, 32'h1);
            wr(`SCC_ADDR_MASK, 32'h1);
            idle(3);
            chk("irq_idle", irq, 1'b0);
            wr(`SCC_ADDR_CTRL, {24'h0, 2'b10, pe[0], 5'h3});
            idle(5);
            chk("irq_set", irq, 1'b1);
            rd("status_set", `SCC_ADDR_STATUS, 32'h1);
            wr(`SCC_ADDR_MASK, 32'h0);
            idle(2);
            chk("irq_masked", irq, 1'b0);
            wr(`SCC_ADDR_STATUS, 32'h1);
            idle(2);
            rd("status_clr", `SCC_ADDR_STATUS, 32'h0);
        end
        wr(`SCC_ADDR_CTRL, 32'h80);
        wr(`SCC_ADDR_AUX, 32'h01);
        tmr_run <= 1'b1;
        idle(20);
        tmr_run <= 1'b0;
        idle(6);
        rd("sync_first", `SCC_ADDR_CTRL, 32'hc0);
        wr(`SCC_ADDR_CTRL, 32'h83);
        idle(8);
        rd("sync_held", `SCC_ADDR_CTRL, 32'hc3);
        tmr_run <= 1'b1;
        idle(20);
        tmr_run <= 1'b0;
        idle(6);
        rd("sync_moved", `SCC_ADDR_CTRL, 32'h83);
        rd("aux_sync", `SCC_ADDR_AUX, 32'h01);
        rstn_i <= 1'b0;
        idle(3);
        rstn_i <= 1'b1;
        rd("ctrl_rerst", `SCC_ADDR_CTRL, 32'h0);
        rd("aux_rerst", `SCC_ADDR_AUX, 32'h0);
        chk("irq_rerst", irq, 1'b0);
        rd("unmapped", 12'h400, 32'h0);
        chk("slverr", serr, 1'b1);
        results();
    end
endmodule

`default_nettype wire
